// file: hdl/sfm_map.svh
// Field encodings and reset values for the serial flash sequencer
`ifndef SFM_MAP_SVH
`define SFM_MAP_SVH
`define SFM_WID_4LINE 2'b10
`define SFM_ADDR_24 4'h7
`define SFM_ADDR_32 4'hf
`define SFM_OPT_1 4'h8
`define SFM_OPT_2 4'hc
`define SFM_OPT_3 4'he
`define SFM_OPT_4 4'hf
`define SFM_XFER_8 4'h8
`define SFM_XFER_16 4'hc
`define SFM_XFER_32 4'hf
`define SFM_CMD_BITS 6'd8
`define SFM_MAP_DATA_BITS 6'd32
`define SFM_CS_IDLE 1'b1
`define SFM_OE_OFF 4'hf
`define SFM_OE_1LINE 4'he
`define SFM_OE_4LINE 4'h0
`endif

// file: hdl/sfm_pkg.sv
// Types shared by the serial flash sequencer
`default_nettype none
package sfm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW = 3'b001,
    ST_HIGH = 3'b010,
    ST_DONE = 3'b011
  } seq_state_t;
  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_OCMD = 3'b001,
    PH_ADDR = 3'b010,
    PH_DMY = 3'b011,
    PH_OPT = 3'b100,
    PH_DATA = 3'b101,
    PH_END = 3'b110
  } phase_t;
endpackage
`default_nettype wire

// file: hdl/serial_flash_manual_xfer.sv
// Serial flash transfer sequencer for mapped reads and manual transfers
// Functional notes
// - Serial clock half period is (rate+1) shifted left by the divider field.
// - Mapped read address goes out on one or four lines.
// - Mapped read sends a 24-bit or 32-bit address per its enable field.
// - Manual command byte uses one or four lines.
// - Manual optional command byte has its own line width.
// - Manual address uses one or four lines.
// - Manual optional data bytes use one or four lines.
// - Manual transfer data uses one or four lines.
// - Manual command phase is sent only when its enable is set.
// - Manual optional command is sent only when its enable is set.
// - Manual address: none, low 24 bits or all 32 bits.
// - Zero to four optional bytes, highest byte first, going downward.
// - Manual transfer data: none, 8, 16 or 32 bits (single flash).
// - Select released at end unless keep is set; then held until next access.
// - Capture data only with read enable; drive data only with write enable.
// - Dummy phase inserts 1 to 8 serial clock cycles.
// - Mapped read sends its 8-bit read command first.
`include "sfm_map.svh"
`default_nettype none
module serial_flash_manual_xfer
  import sfm_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Serial clock rate
  input wire logic [7:0] i_bit_rate,
  input wire logic [1:0] i_bit_div,
  // Manual transfer control
  input wire logic i_man_start,
  input wire logic i_man_rd_en,
  input wire logic i_man_wr_en,
  input wire logic i_man_cs_keep,
  input wire logic i_man_cmd_en,
  input wire logic [1:0] i_man_cmd_wid,
  input wire logic i_man_ocmd_en,
  input wire logic [1:0] i_man_ocmd_wid,
  input wire logic [3:0] i_man_addr_en,
  input wire logic [1:0] i_man_addr_wid,
  input wire logic i_man_dmy_en,
  input wire logic [2:0] i_man_dmy_cnt,
  input wire logic [3:0] i_man_opt_en,
  input wire logic [1:0] i_man_opt_wid,
  input wire logic [3:0] i_man_xfer_en,
  input wire logic [1:0] i_man_xfer_wid,
  input wire logic [7:0] i_man_cmd,
  input wire logic [7:0] i_man_ocmd,
  input wire logic [31:0] i_man_addr,
  input wire logic [31:0] i_man_opt_bytes,
  input wire logic [31:0] i_man_wdata,
  // Mapped read request
  input wire logic i_map_start,
  input wire logic [7:0] i_map_cmd,
  input wire logic [1:0] i_map_cmd_wid,
  input wire logic [31:0] i_map_addr,
  input wire logic [3:0] i_map_addr_en,
  input wire logic [1:0] i_map_addr_wid,
  input wire logic i_map_dmy_en,
  input wire logic [2:0] i_map_dmy_cnt,
  input wire logic [1:0] i_map_data_wid,
  // Flash pins
  output logic o_flash_serial_clock,
  output logic o_flash_chip_select_n,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe_n,
  input wire logic [3:0] i_io_in,
  // Status and read data
  output logic o_busy,
  output logic o_rd_valid,
  output logic [31:0] o_rd_data,
  input wire logic i_rd_ready
);

  function automatic logic is4(input logic [1:0] w);
    is4 = (w == `SFM_WID_4LINE);
  endfunction

  function automatic logic [5:0] cyc_of(input logic [5:0] bits, input logic w4);
    cyc_of = w4 ? {2'b00, bits[5:2]} : bits;
  endfunction

  function automatic phase_t first_en(input logic [5:0] en, input logic [2:0] from);
    first_en = PH_END;
    for (int i = 5; i >= 0; i--) begin
      if (en[i] && (3'(i) >= from)) first_en = phase_t'(3'(i));
    end
  endfunction

  function automatic logic [7:0] drive(input phase_t p, input logic w4, input logic [31:0] s,
                                       input logic wr);
    if (p == PH_DMY || (p == PH_DATA && !wr)) drive = {4'h0, `SFM_OE_OFF};
    else if (w4) drive = {s[31:28], `SFM_OE_4LINE};
    else drive = {3'b000, s[31], `SFM_OE_1LINE};
  endfunction

  seq_state_t state_q, state_d;
  phase_t ph_q, ph_d, nx;
  logic [5:0] en_q, en_d, w4_q, w4_d, cfg_en, cfg_w4;
  logic [5:0] cyc_q [6];
  logic [5:0] cyc_d [6];
  logic [5:0] cfg_cyc [6];
  logic [31:0] val_q [6];
  logic [31:0] val_d [6];
  logic [31:0] cfg_val [6];
  logic [5:0] cfg_bits [6];
  logic [31:0] sh_q, sh_d;
  logic [5:0] cnt_q, cnt_d, dbits_q, dbits_d;
  logic [11:0] half_q, half_d, div_q, div_d;
  logic rd_q, rd_d, wr_q, wr_d, keep_q, keep_d;
  logic sck_q, sck_d, cs_q, cs_d, busy_q, busy_d;
  logic [3:0] out_q, out_d, oe_q, oe_d;
  logic head_v_q, head_v_d, tail_v_q, tail_v_d;
  logic [31:0] head_q, head_d, tail_q, tail_d;
  logic go, man, tick, push;
  logic [31:0] push_word;
  logic [3:0] ae;
  logic [2:0] nopt;

  assign go = i_man_start || i_map_start;
  assign man = i_man_start;
  assign tick = (div_q == half_q - 12'h001);

  // Phase set-up taken when a transfer starts; manual wins over mapped
  always_comb begin
    ae = man ? i_man_addr_en : i_map_addr_en;
    nopt = 3'b000;
    case (i_man_opt_en)
      `SFM_OPT_1: nopt = 3'd1;
      `SFM_OPT_2: nopt = 3'd2;
      `SFM_OPT_3: nopt = 3'd3;
      `SFM_OPT_4: nopt = 3'd4;
      default: nopt = 3'd0;
    endcase
    cfg_en[PH_CMD] = man ? i_man_cmd_en : 1'b1;
    cfg_w4[PH_CMD] = is4(man ? i_man_cmd_wid : i_map_cmd_wid);
    cfg_val[PH_CMD] = {(man ? i_man_cmd : i_map_cmd), 24'h000000};
    cfg_bits[PH_CMD] = `SFM_CMD_BITS;
    cfg_en[PH_OCMD] = man && i_man_ocmd_en;
    cfg_w4[PH_OCMD] = is4(i_man_ocmd_wid);
    cfg_val[PH_OCMD] = {i_man_ocmd, 24'h000000};
    cfg_bits[PH_OCMD] = `SFM_CMD_BITS;
    cfg_en[PH_ADDR] = (ae == `SFM_ADDR_24) || (ae == `SFM_ADDR_32);
    cfg_w4[PH_ADDR] = is4(man ? i_man_addr_wid : i_map_addr_wid);
    cfg_val[PH_ADDR] = (ae == `SFM_ADDR_32) ? (man ? i_man_addr : i_map_addr)
                     : {(man ? i_man_addr[23:0] : i_map_addr[23:0]), 8'h00};
    cfg_bits[PH_ADDR] = (ae == `SFM_ADDR_32) ? 6'd32 : 6'd24;
    cfg_en[PH_DMY] = man ? i_man_dmy_en : i_map_dmy_en;
    cfg_w4[PH_DMY] = 1'b0;
    cfg_val[PH_DMY] = 32'h00000000;
    cfg_bits[PH_DMY] = 6'd0;
    cfg_en[PH_OPT] = man && (nopt != 3'd0);
    cfg_w4[PH_OPT] = is4(i_man_opt_wid);
    cfg_val[PH_OPT] = i_man_opt_bytes;
    cfg_bits[PH_OPT] = {nopt, 3'b000};
    cfg_bits[PH_DATA] = 6'd0;
    if (!man) cfg_bits[PH_DATA] = `SFM_MAP_DATA_BITS;
    else if (i_man_xfer_en == `SFM_XFER_8) cfg_bits[PH_DATA] = 6'd8;
    else if (i_man_xfer_en == `SFM_XFER_16) cfg_bits[PH_DATA] = 6'd16;
    else if (i_man_xfer_en == `SFM_XFER_32) cfg_bits[PH_DATA] = 6'd32;
    cfg_en[PH_DATA] = (cfg_bits[PH_DATA] != 6'd0);
    cfg_w4[PH_DATA] = is4(man ? i_man_xfer_wid : i_map_data_wid);
    cfg_val[PH_DATA] = i_man_wdata << (6'd32 - cfg_bits[PH_DATA]);
    for (int i = 0; i < 6; i++) begin
      cfg_cyc[i] = cyc_of(cfg_bits[i], cfg_w4[i]);
    end
    cfg_cyc[PH_DMY] = {3'b000, man ? i_man_dmy_cnt : i_map_dmy_cnt} + 6'd1;
  end

  // Sequencer
  always_comb begin
    state_d = state_q;
    ph_d = ph_q;
    en_d = en_q;
    w4_d = w4_q;
    cyc_d = cyc_q;
    val_d = val_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    dbits_d = dbits_q;
    half_d = half_q;
    div_d = div_q;
    rd_d = rd_q;
    wr_d = wr_q;
    keep_d = keep_q;
    sck_d = sck_q;
    cs_d = cs_q;
    busy_d = busy_q;
    out_d = out_q;
    oe_d = oe_q;
    push = 1'b0;
    push_word = sh_q;
    if (dbits_q != 6'd32) push_word = sh_q & ((32'h00000001 << dbits_q) - 32'h00000001);
    nx = first_en(en_q, 3'(ph_q) + 3'd1);
    case (state_q)
      ST_IDLE: begin
        if (go) begin
          en_d = cfg_en;
          w4_d = cfg_w4;
          cyc_d = cfg_cyc;
          val_d = cfg_val;
          dbits_d = cfg_bits[PH_DATA];
          half_d = 12'({4'h0, i_bit_rate} + 12'h001) << i_bit_div;
          div_d = 12'h000;
          rd_d = man ? i_man_rd_en : 1'b1;
          wr_d = man && i_man_wr_en;
          keep_d = man && i_man_cs_keep;
          cs_d = 1'b0;
          busy_d = 1'b1;
          ph_d = first_en(cfg_en, 3'd0);
          if (first_en(cfg_en, 3'd0) == PH_END) begin
            state_d = ST_DONE;
          end else begin
            sh_d = cfg_val[ph_d];
            cnt_d = cfg_cyc[ph_d];
            {out_d, oe_d} = drive(ph_d, cfg_w4[ph_d], cfg_val[ph_d], wr_d);
            state_d = ST_LOW;
          end
        end
      end
      ST_LOW: begin
        div_d = tick ? 12'h000 : div_q + 12'h001;
        if (tick) begin
          sck_d = 1'b1;
          // Sample on rising edge, shift MSB first
          if (w4_q[ph_q]) sh_d = {sh_q[27:0], i_io_in};
          else sh_d = {sh_q[30:0], i_io_in[1]};
          state_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        div_d = tick ? 12'h000 : div_q + 12'h001;
        if (tick) begin
          sck_d = 1'b0;
          state_d = ST_LOW;
          if (cnt_q == 6'd1) begin
            // Next phase starts on the very next clock
            ph_d = nx;
            if (nx == PH_END) begin
              state_d = ST_DONE;
              oe_d = `SFM_OE_OFF;
            end else begin
              sh_d = val_q[nx];
              cnt_d = cyc_q[nx];
              {out_d, oe_d} = drive(nx, w4_q[nx], val_q[nx], wr_q);
            end
          end else begin
            cnt_d = cnt_q - 6'd1;
            {out_d, oe_d} = drive(ph_q, w4_q[ph_q], sh_q, wr_q);
          end
        end
      end
      ST_DONE: begin
        // A full buffer stalls the end of the transfer, so no word is lost
        if (!(en_q[PH_DATA] && rd_q) || !tail_v_q) begin
          push = en_q[PH_DATA] && rd_q;
          cs_d = !keep_q;
          busy_d = 1'b0;
          ph_d = PH_CMD;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      ph_q <= PH_CMD;
      en_q <= 6'h00;
      w4_q <= 6'h00;
      for (int i = 0; i < 6; i++) begin
        cyc_q[i] <= 6'h00;
        val_q[i] <= 32'h00000000;
      end
      sh_q <= 32'h00000000;
      cnt_q <= 6'h00;
      dbits_q <= 6'h00;
      half_q <= 12'h001;
      div_q <= 12'h000;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      keep_q <= 1'b0;
      sck_q <= 1'b0;
      cs_q <= `SFM_CS_IDLE;
      busy_q <= 1'b0;
      out_q <= 4'h0;
      oe_q <= `SFM_OE_OFF;
    end else begin
      state_q <= state_d;
      ph_q <= ph_d;
      en_q <= en_d;
      w4_q <= w4_d;
      cyc_q <= cyc_d;
      val_q <= val_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      dbits_q <= dbits_d;
      half_q <= half_d;
      div_q <= div_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      keep_q <= keep_d;
      sck_q <= sck_d;
      cs_q <= cs_d;
      busy_q <= busy_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  // Two-entry read buffer: head feeds the port, tail absorbs a stalled word
  always_comb begin
    head_v_d = head_v_q;
    head_d = head_q;
    tail_v_d = tail_v_q;
    tail_d = tail_q;
    if (head_v_q && i_rd_ready) begin
      head_v_d = tail_v_q;
      head_d = tail_q;
      tail_v_d = 1'b0;
    end
    if (push) begin
      if (!head_v_d) begin
        head_v_d = 1'b1;
        head_d = push_word;
      end else begin
        tail_v_d = 1'b1;
        tail_d = push_word;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      head_v_q <= 1'b0;
      head_q <= 32'h00000000;
      tail_v_q <= 1'b0;
      tail_q <= 32'h00000000;
    end else begin
      head_v_q <= head_v_d;
      head_q <= head_d;
      tail_v_q <= tail_v_d;
      tail_q <= tail_d;
    end
  end

  assign o_flash_serial_clock = sck_q;
  assign o_flash_chip_select_n = cs_q;
  assign o_io_out = out_q;
  assign o_io_oe_n = oe_q;
  assign o_busy = busy_q;
  assign o_rd_valid = head_v_q;
  assign o_rd_data = head_q;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  div_bound_a: assert property (
    (state_q != ST_IDLE && state_q != ST_DONE) |-> div_q < half_q)
    else $error("divider ran past half period");
  addr_len_a: assert property (
    (state_q == ST_IDLE && go && ae == `SFM_ADDR_24 && !cfg_w4[PH_ADDR])
    |=> cyc_q[PH_ADDR] == 6'd24)
    else $error("24-bit address cycle count wrong");
  cmd_skip_a: assert property (
    (state_q == ST_IDLE && i_man_start && !i_man_cmd_en) |=> ph_q != PH_CMD)
    else $error("disabled command phase sent");
  ocmd_skip_a: assert property (
    (state_q == ST_IDLE && i_man_start && !i_man_ocmd_en) |=> !en_q[PH_OCMD])
    else $error("disabled optional command armed");
  opt_two_a: assert property (
    (state_q == ST_IDLE && i_man_start && i_man_opt_en == `SFM_OPT_2)
    |=> val_q[PH_OPT][31:16] == $past(i_man_opt_bytes[31:16])
        && cyc_q[PH_OPT] == (w4_q[PH_OPT] ? 6'd4 : 6'd16))
    else $error("two optional bytes mis-set");
  order_a: assert property (
    (state_q == ST_HIGH && tick && cnt_q == 6'd1 && nx != PH_END)
    |=> state_q == ST_LOW && ph_q > $past(ph_q) && o_flash_serial_clock == 1'b0)
    else $error("phase order or gap broken");
  keep_a: assert property (
    (state_q == ST_DONE ##1 state_q == ST_IDLE) |-> o_flash_chip_select_n == !keep_q)
    else $error("select level after transfer wrong");
  no_write_a: assert property (
    (state_q == ST_LOW && ph_q == PH_DATA && !wr_q) |-> o_io_oe_n == `SFM_OE_OFF)
    else $error("data driven without write enable");
  quad_oe_a: assert property (
    (state_q == ST_LOW && ph_q != PH_DMY && ph_q != PH_DATA)
    |-> o_io_oe_n == (w4_q[ph_q] ? `SFM_OE_4LINE : `SFM_OE_1LINE))
    else $error("line width of drive wrong");
  dummy_len_a: assert property (
    (state_q == ST_IDLE && i_man_start && i_man_dmy_en)
    |=> cyc_q[PH_DMY] == {3'b000, $past(i_man_dmy_cnt)} + 6'd1)
    else $error("dummy cycle count wrong");

endmodule
`default_nettype wire

// file: testbench/flash_model.sv
// Behavioural serial flash that logs each bus cycle and returns a read word
`default_nettype none
module flash_model (
  // Flash pins
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  input wire logic [3:0] i_oe_n,
  output logic [3:0] o_io,
  // Reply set by the bench
  input wire logic [31:0] i_reply,
  input wire logic [15:0] i_skip,
  input wire logic [5:0] i_nbits,
  input wire logic i_wid4
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cap_io [0:255];
  logic [3:0] cap_oe [0:255];
  logic [15:0] rises = 16'h0000;
  int k;
  int n;
  initial o_io = 4'h5;
  always @(posedge i_sck) begin
    cap_io[rises[7:0]] = i_io;
    cap_oe[rises[7:0]] = i_oe_n;
    rises = rises + 16'h0001;
  end
  // Outside the reply the lines keep changing, so a stale value is never mistaken for data
  always @(negedge i_sck or negedge i_cs_n or posedge i_cs_n) begin
    k = int'(rises - i_skip);
    n = i_wid4 ? i_nbits / 4 : i_nbits;
    if (i_cs_n || rises < i_skip || k >= n) o_io = ~o_io;
    else if (i_wid4) o_io = i_reply[i_nbits - 4 - 4 * k +: 4];
    else o_io = {2'b00, i_reply[i_nbits - 1 - k], 1'b0};
  end
endmodule
`default_nettype wire

// file: testbench/serial_flash_manual_xfer_bench.sv
// Self-checking bench for the serial flash sequencer
`default_nettype none
module serial_flash_manual_xfer_bench;
  import sfm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ms, rd, wr, keep, ce, oce, de, mps, mde, rdy, wid4;
  logic [1:0] cw, ow, aw, pw, xw, mcw, maw, mdw, div;
  logic [3:0] ae, pe, xe, mae, io_o, oe_n, io_i, fl_o;
  logic [2:0] dc, mdc;
  logic [7:0] rate, cmd, ocmd, mcmd;
  logic [31:0] addr, opt, wd, maddr, reply, rdat;
  logic [15:0] skip = 16'h0000;
  logic [15:0] base;
  logic [5:0] nbits;
  logic sck, cs_n, busy, vld;
  logic [11:0] exq [$];
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  // Either party may drive a line; the design wins where it enables
  assign io_i = (~oe_n & io_o) | (oe_n & fl_o);
  serial_flash_manual_xfer u_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_bit_rate(rate), .i_bit_div(div),
    .i_man_start(ms), .i_man_rd_en(rd), .i_man_wr_en(wr), .i_man_cs_keep(keep),
    .i_man_cmd_en(ce), .i_man_cmd_wid(cw), .i_man_ocmd_en(oce), .i_man_ocmd_wid(ow),
    .i_man_addr_en(ae), .i_man_addr_wid(aw), .i_man_dmy_en(de), .i_man_dmy_cnt(dc),
    .i_man_opt_en(pe), .i_man_opt_wid(pw), .i_man_xfer_en(xe), .i_man_xfer_wid(xw),
    .i_man_cmd(cmd), .i_man_ocmd(ocmd), .i_man_addr(addr), .i_man_opt_bytes(opt),
    .i_man_wdata(wd), .i_map_start(mps), .i_map_cmd(mcmd), .i_map_cmd_wid(mcw),
    .i_map_addr(maddr), .i_map_addr_en(mae), .i_map_addr_wid(maw), .i_map_dmy_en(mde),
    .i_map_dmy_cnt(mdc), .i_map_data_wid(mdw), .o_flash_serial_clock(sck),
    .o_flash_chip_select_n(cs_n), .o_io_out(io_o), .o_io_oe_n(oe_n), .i_io_in(io_i),
    .o_busy(busy), .o_rd_valid(vld), .o_rd_data(rdat), .i_rd_ready(rdy));
  flash_model u_flash (
    .i_sck(sck), .i_cs_n(cs_n), .i_io(io_o), .i_oe_n(oe_n), .o_io(fl_o),
    .i_reply(reply), .i_skip(skip), .i_nbits(nbits), .i_wid4(wid4));
  task automatic give_verdict;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic tick;
    @(posedge clk);
    #2;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk4(input logic [3:0] g, input logic [3:0] e);
    chk32({28'h0, g}, {28'h0, e});
  endtask
  task automatic chk1(input logic g, input logic e);
    chk32({31'h0, g}, {31'h0, e});
  endtask
  task automatic cfg0;
    {ms, rd, wr, keep, ce, oce, de, mps, mde, rdy, wid4, nbits} = '0;
    {cw, ow, aw, pw, xw, mcw, maw, mdw, div} = '0;
    {ae, pe, xe, mae, dc, mdc, rate, cmd, ocmd, mcmd} = '0;
    {addr, opt, wd, maddr, reply} = '0;
  endtask
  // Each entry: lane enables, compared lanes, lane values for one serial clock
  task automatic put(input logic w4, input logic [31:0] v, input int n, input logic drv);
    for (int i = (w4 ? n - 4 : n - 1); i >= 0; i -= (w4 ? 4 : 1))
      exq.push_back({drv ? (w4 ? 4'h0 : 4'he) : 4'hf, drv ? (w4 ? 4'hf : 4'h1) : 4'h0,
                     w4 ? v[i +: 4] : {3'h0, v[i]}});
  endtask
  task automatic kick(input logic m, input int pre);
    base = u_flash.rises;
    skip = base + 16'(pre);
    if (m) mps = 1'b1;
    else ms = 1'b1;
    tick();
    {ms, mps} = 2'b00;
  endtask
  task automatic done;
    for (int t = 0; t < 4000 && busy !== 1'b0; t++) tick();
    chk32(32'(u_flash.rises - base), 32'(exq.size())); // cycle count
    foreach (exq[i]) begin
      chk4(u_flash.cap_oe[8'(base + i)], exq[i][11:8]); // lane use
      chk4(u_flash.cap_io[8'(base + i)] & exq[i][7:4], exq[i][3:0]); // bit order
    end
    exq.delete();
  endtask
  task automatic pop(input logic [31:0] e);
    chk1(vld, 1'b1); // capture
    chk32(rdat, e); // length
    rdy = 1'b1;
    tick();
    rdy = 1'b0;
  endtask
  task automatic t_cmd;
    cfg0();
    ce = 1'b1;
    cmd = 8'ha5;
    put(0, cmd, 8, 1); // one line
    kick(0, 0);
    done(); // sent
    chk1(cs_n, 1'b1); // released
    $display("t_cmd done");
  endtask
  task automatic t_phase;
    cfg0();
    {ce, cw, cmd, oce, ocmd} = {1'b1, 2'b10, 8'h3c, 1'b1, 8'h96};
    {ae, aw, addr, de, dc} = {4'hf, 2'b10, 32'h12345678, 1'b1, 3'd2};
    {pe, pw, opt, xe, wr, wd} = {4'hc, 2'b10, 32'hdeadbeef, 4'hc, 1'b1, 32'h0000c3a5};
    put(1, cmd, 8, 1); // four lines
    put(0, ocmd, 8, 1); // own width
    put(1, addr, 32, 1); // full address
    put(0, 0, 3, 0); // dummy count
    put(1, opt >> 16, 16, 1); // two bytes
    put(0, wd, 16, 1); // write length
    kick(0, 0);
    done(); // order
    chk1(vld, 1'b0); // no capture
    $display("t_phase done");
  endtask
  task automatic t_opt;
    for (int j = 0; j < 4; j++) begin
      cfg0();
      {oce, ow, ocmd, addr, opt} = {1'b1, 2'b10, 8'h69, 32'hff00a5c3, 32'h8142c3e7};
      ae = j ? 4'h7 : 4'h0;
      pe = {1'b1, j > 0, j > 1, j > 2};
      put(1, ocmd, 8, 1); // skip
      if (j) put(0, addr, 24, 1); // low bits
      put(0, opt >> (24 - 8 * j), 8 * (j + 1), 1); // byte order
      kick(0, 0);
      done(); // no gap
    end
    $display("t_opt done");
  endtask
  task automatic t_read;
    for (int j = 0; j < 3; j++) begin
      cfg0();
      {ce, cmd, rd, reply} = {1'b1, 8'h6b, 1'b1, 32'h89abcdef};
      xe = {1'b1, j > 0, j > 1, j > 1};
      xw = j ? 2'b10 : 2'b00;
      wid4 = (j > 0);
      nbits = 6'(8 << j);
      put(0, cmd, 8, 1);
      put(wid4, 0, 8 << j, 0); // read width
      kick(0, 8);
      if (j == 2) begin
        repeat (100) tick();
        chk1(busy, 1'b1); // full buffer stall
        pop(32'h000000ef); // eight bits
      end
      done();
    end
    pop(32'h0000cdef); // sixteen bits
    pop(32'h89abcdef); // word
    chk1(vld, 1'b0); // drained
    $display("t_read done");
  endtask
  task automatic t_keep;
    cfg0();
    {keep, ce, wr, cmd} = {1'b1, 1'b1, 1'b1, 8'h06};
    put(0, cmd, 8, 1);
    kick(0, 0);
    done();
    tick();
    chk1(cs_n, 1'b0); // held
    keep = 1'b0;
    cmd = 8'h05;
    put(0, cmd, 8, 1);
    kick(0, 0);
    done();
    chk1(cs_n, 1'b1); // released
    $display("t_keep done");
  endtask
  task automatic t_map;
    int t;
    for (int j = 0; j < 2; j++) begin
      cfg0();
      {rate, div, mcmd, maddr, mde, mdc} = {8'h01, 2'b01, 8'heb, 32'h00c0ffee, 1'b1, 3'd1};
      {mdw, reply, nbits, wid4} = {2'b10, 32'h13579bdf, 6'd32, 1'b1};
      mae = j ? 4'h7 : 4'hf;
      maw = j ? 2'b00 : 2'b10;
      put(0, mcmd, 8, 1); // command first
      put(!j, maddr, j ? 24 : 32, 1); // address
      put(0, 0, 2, 0);
      put(1, 0, 32, 0);
      kick(1, j ? 34 : 18);
      for (t = 0; t < 99 && sck !== 1'b1; t++) tick();
      // Count one full serial clock period, rise to rise
      t = 0;
      while (t < 99 && sck !== 1'b0) begin
        tick();
        t++;
      end
      while (t < 99 && sck !== 1'b1) begin
        tick();
        t++;
      end
      chk32(t, 2 * ((1 + 1) << 1)); // rate
      done();
      pop(reply);
    end
    $display("t_map done");
  endtask
  initial begin
    cfg0();
    repeat (2) @(posedge clk);
    #2 rst_n = 1'b1;
    t_cmd();
    t_phase();
    t_opt();
    t_read();
    t_keep();
    t_map();
    give_verdict();
  end
endmodule
`default_nettype wire
